// >>> peripheral_block_enable_control.sv
// Global reset and clock gating sequencer with AXI4-Lite register access
`timescale 1ns/1ps

module peripheral_block_enable_control #(
    parameter int NUM_BLOCKS = 9,
    parameter int ADDR_W     = 8
) (
    // Clock and reset
    input  wire logic                  i_clock,
    input  wire logic                  i_rst,
    // AXI4-Lite write address channel
    input  wire logic [ADDR_W-1:0]     i_awaddr,
    input  wire logic [2:0]            i_awprot,
    input  wire logic                  i_awvalid,
    output logic                       o_awready,
    // AXI4-Lite write data channel
    input  wire logic [31:0]           i_wdata,
    input  wire logic [3:0]            i_wstrb,
    input  wire logic                  i_wvalid,
    output logic                       o_wready,
    // AXI4-Lite write response channel
    output logic [1:0]                 o_bresp,
    output logic                       o_bvalid,
    input  wire logic                  i_bready,
    // AXI4-Lite read address channel
    input  wire logic [ADDR_W-1:0]     i_araddr,
    input  wire logic [2:0]            i_arprot,
    input  wire logic                  i_arvalid,
    output logic                       o_arready,
    // AXI4-Lite read data channel
    output logic [31:0]                o_rdata,
    output logic [1:0]                 o_rresp,
    output logic                       o_rvalid,
    input  wire logic                  i_rready,
    // Per-block reset and clock enable, index 0 is the register block
    output logic [NUM_BLOCKS-1:0]      o_block_reset,
    output logic [NUM_BLOCKS-1:0]      o_block_clk_en,
    // Peripheral settings word for the rest of the peripheral
    output logic [31:0]                o_periph_settings
);

    // Register storage
    logic                    global_enable_reg;
    logic [31:0]             wdata_reg;
    logic [3:0]              wstrb_reg;
    logic [ADDR_W-1:0]       awaddr_reg;
    logic [NUM_BLOCKS-1:0]   block_run;
    logic [NUM_BLOCKS-1:0]   block_off;
    logic [block_enable_pkg::STATUS_WIDTH-1:0] status_reg;

    // Write is performed once both address and data have been taken
    logic do_write;
    assign do_write = !o_awready && !o_wready && !o_bvalid;

    // Protection inputs have no effect; every access is treated alike
    logic unused_ok;
    assign unused_ok = &{1'b0, i_awprot, i_arprot};

    // Write address channel; ready drops until the response is taken
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_awready  <= 1'b1;
            awaddr_reg <= '0;
        end
        else if (i_awvalid && o_awready)
        begin
            o_awready  <= 1'b0;
            awaddr_reg <= i_awaddr;
        end
        else if (o_bvalid && i_bready)
        begin
            o_awready  <= 1'b1;
        end
    end

    // Write data channel, taken independently of the address
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_wready  <= 1'b1;
            wdata_reg <= '0;
            wstrb_reg <= '0;
        end
        else if (i_wvalid && o_wready)
        begin
            o_wready  <= 1'b0;
            wdata_reg <= i_wdata;
            wstrb_reg <= i_wstrb;
        end
        else if (o_bvalid && i_bready)
        begin
            o_wready  <= 1'b1;
        end
    end

    // Write response; unmapped or read-only targets answer SLVERR
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_bvalid <= 1'b0;
            o_bresp  <= block_enable_pkg::RESP_OKAY;
        end
        else if (do_write)
        begin
            o_bvalid <= 1'b1;
            if (awaddr_reg == block_enable_pkg::GLOBAL_ENABLE_OFFSET ||
                awaddr_reg == block_enable_pkg::PERIPH_SETTINGS_OFFSET)
                o_bresp <= block_enable_pkg::RESP_OKAY;
            else
                o_bresp <= block_enable_pkg::RESP_SLVERR;
        end
        else if (o_bvalid && i_bready)
        begin
            o_bvalid <= 1'b0;
        end
    end

    // Global enable bit; only bit 0 is stored
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            global_enable_reg <= block_enable_pkg::GLOBAL_ENABLE_RESET[0];
        else if (do_write && wstrb_reg[0] &&
                 awaddr_reg == block_enable_pkg::GLOBAL_ENABLE_OFFSET)
            global_enable_reg <= wdata_reg[block_enable_pkg::GLOBAL_ENABLE_BIT];
    end

    // Settings word; the low PLL bits are stored as written since software
    // is expected to keep them at zero and nothing here acts on them
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            o_periph_settings <= block_enable_pkg::PERIPH_SETTINGS_RESET;
        else if (do_write &&
                 awaddr_reg == block_enable_pkg::PERIPH_SETTINGS_OFFSET)
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (wstrb_reg[i])
                    o_periph_settings[8*i +: 8] <= wdata_reg[8*i +: 8];
            end
        end
    end

    // Per-block sequencer: clock first then reset release on the way up,
    // reset first then clock stop on the way down, so no block sees a
    // clock edge while half reset
    for (genvar b = 0; b < NUM_BLOCKS; b++)
    begin : g_block
        block_enable_pkg::seq_state_t        state_reg;
        logic [block_enable_pkg::SEQ_CNT_W-1:0] cnt_reg;

        always_ff @(posedge i_clock or posedge i_rst)
        begin
            if (i_rst)
            begin
                // Module reset forces every block into reset, clock off
                state_reg           <= block_enable_pkg::SEQ_OFF;
                cnt_reg             <= '0;
                o_block_reset[b]    <= 1'b1;
                o_block_clk_en[b]   <= 1'b0;
            end
            else
            begin
                case (state_reg)
                    block_enable_pkg::SEQ_OFF:
                    begin
                        if (global_enable_reg)
                        begin
                            state_reg         <= block_enable_pkg::SEQ_CLK_ON;
                            o_block_clk_en[b] <= 1'b1;
                            cnt_reg           <= '0;
                        end
                    end
                    block_enable_pkg::SEQ_CLK_ON:
                    begin
                        // Reset held while the gated clock settles
                        if (cnt_reg == block_enable_pkg::SEQ_CNT_W'(
                                block_enable_pkg::CLK_SETTLE_CYC - 1))
                        begin
                            state_reg        <= block_enable_pkg::SEQ_RUN;
                            o_block_reset[b] <= 1'b0;
                        end
                        else
                            cnt_reg <= cnt_reg + 1'b1;
                    end
                    block_enable_pkg::SEQ_RUN:
                    begin
                        if (!global_enable_reg)
                        begin
                            state_reg        <= block_enable_pkg::SEQ_RST_ON;
                            o_block_reset[b] <= 1'b1;
                            cnt_reg          <= '0;
                        end
                    end
                    block_enable_pkg::SEQ_RST_ON:
                    begin
                        // Clock keeps running so the reset is seen
                        if (cnt_reg == block_enable_pkg::SEQ_CNT_W'(
                                block_enable_pkg::RESET_HOLD_CYC - 1))
                        begin
                            state_reg         <= block_enable_pkg::SEQ_OFF;
                            o_block_clk_en[b] <= 1'b0;
                        end
                        else
                            cnt_reg <= cnt_reg + 1'b1;
                    end
                    default:
                    begin
                        state_reg         <= block_enable_pkg::SEQ_RST_ON;
                        o_block_reset[b]  <= 1'b1;
                        cnt_reg           <= '0;
                    end
                endcase
            end
        end

        // Settled states, used for status only
        assign block_run[b] = (state_reg == block_enable_pkg::SEQ_RUN);
        assign block_off[b] = (state_reg == block_enable_pkg::SEQ_OFF);

        // Status follows only completed transitions; bit n+1 is block n.
        // The all-ones reset value shows only while module reset is held:
        // once released the blocks sit off and the bits fall a cycle later
        always_ff @(posedge i_clock or posedge i_rst)
        begin
            if (i_rst)
                status_reg[b + 1] <=
                    block_enable_pkg::ENABLE_STATUS_RESET[b + 1];
            else if (block_run[b])
                status_reg[b + 1] <= 1'b1;
            else if (block_off[b])
                status_reg[b + 1] <= 1'b0;
        end
    end

    // Global status: all running or all off; mixed keeps the last value
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            status_reg[block_enable_pkg::GLOBAL_STATUS_BIT] <=
                block_enable_pkg::ENABLE_STATUS_RESET[0];
        else if (&block_run)
            status_reg[block_enable_pkg::GLOBAL_STATUS_BIT] <= 1'b1;
        else if (&block_off)
            status_reg[block_enable_pkg::GLOBAL_STATUS_BIT] <= 1'b0;
    end

    // Read channel; data is captured at the address handshake
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
            o_rdata   <= '0;
            o_rresp   <= block_enable_pkg::RESP_OKAY;
        end
        else if (i_arvalid && o_arready)
        begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            o_rresp   <= block_enable_pkg::RESP_OKAY;
            case (i_araddr)
                block_enable_pkg::GLOBAL_ENABLE_OFFSET:
                    o_rdata <= {31'h0000_0000, global_enable_reg};
                block_enable_pkg::ENABLE_STATUS_OFFSET:
                    o_rdata <= {22'h00_0000, status_reg};
                block_enable_pkg::PERIPH_SETTINGS_OFFSET:
                    o_rdata <= o_periph_settings;
                default:
                begin
                    o_rdata <= '0;
                    o_rresp <= block_enable_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (o_rvalid && i_rready)
        begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
        end
    end

endmodule : peripheral_block_enable_control

// >>> block_enable_pkg.sv
// Constants and types shared by the peripheral block enable control
package block_enable_pkg;

    // Register byte offsets
    localparam logic [7:0] GLOBAL_ENABLE_OFFSET   = 8'h30;
    localparam logic [7:0] ENABLE_STATUS_OFFSET   = 8'h34;
    localparam logic [7:0] PERIPH_SETTINGS_OFFSET = 8'h20;

    // Field positions
    localparam int GLOBAL_ENABLE_BIT    = 0;
    localparam int GLOBAL_STATUS_BIT    = 0;
    localparam int FIRST_BLOCK_STAT_BIT = 1;
    localparam int STATUS_WIDTH         = 10;

    // Status bit of each logical block
    localparam int REGS_BLOCK_STATUS_BIT    = 1;
    localparam int LOAD_STORE_STATUS_BIT    = 2;
    localparam int MEMORY_ACCESS_STATUS_BIT = 3;
    localparam int MSG_TX_STATUS_BIT        = 4;
    localparam int MSG_RX_STATUS_BIT        = 5;
    localparam int PORT0_STATUS_BIT         = 6;
    localparam int PORT1_STATUS_BIT         = 7;
    localparam int PORT2_STATUS_BIT         = 8;
    localparam int PORT3_STATUS_BIT         = 9;

    // Reset values
    localparam logic [31:0] GLOBAL_ENABLE_RESET    = 32'h0000_0000;
    localparam logic [9:0]  ENABLE_STATUS_RESET    = 10'h3FF;
    localparam logic [31:0] PERIPH_SETTINGS_RESET  = 32'h0000_0000;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Sequencing times and their cycle counts at the 40 MHz clock
    localparam int CLOCK_MHZ        = 40;
    localparam int CLK_SETTLE_NS    = 100;
    localparam int RESET_HOLD_NS    = 100;
    localparam int CLK_SETTLE_CYC   =
        (CLK_SETTLE_NS * CLOCK_MHZ + 999) / 1000 < 1 ? 1 :
        (CLK_SETTLE_NS * CLOCK_MHZ + 999) / 1000;
    localparam int RESET_HOLD_CYC   =
        (RESET_HOLD_NS * CLOCK_MHZ + 999) / 1000 < 1 ? 1 :
        (RESET_HOLD_NS * CLOCK_MHZ + 999) / 1000;
    localparam int SEQ_CNT_W        = 8;

    // Per-block power sequence states
    typedef enum logic [1:0] {
        SEQ_OFF,
        SEQ_CLK_ON,
        SEQ_RUN,
        SEQ_RST_ON
    } seq_state_t;

endpackage : block_enable_pkg

// >>> peripheral_block_enable_control_chk.sv
// Bus handshake and block sequencing checks for the enable control
`timescale 1ns/1ps
module peripheral_block_enable_control_chk #(
    parameter int NUM_BLOCKS = 9,
    parameter int ADDR_W     = 8
) (
    // Clock and reset
    input wire logic                  i_clock,
    input wire logic                  i_rst,
    // Register bus handshakes
    input wire logic                  i_awvalid,
    input wire logic                  o_awready,
    input wire logic                  i_wvalid,
    input wire logic                  o_wready,
    input wire logic [1:0]            o_bresp,
    input wire logic                  o_bvalid,
    input wire logic                  i_bready,
    input wire logic                  i_arvalid,
    input wire logic                  o_arready,
    input wire logic [31:0]           o_rdata,
    input wire logic                  o_rvalid,
    input wire logic                  i_rready,
    // Block controls
    input wire logic [NUM_BLOCKS-1:0] o_block_reset,
    input wire logic [NUM_BLOCKS-1:0] o_block_clk_en
);
    // One domain, so clocking and reset are given once
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    // Clocks must settle before reset lets go, or blocks start glitched
    sequence clk_lead;
        o_block_reset[0] [*4] ##[1:4] !o_block_reset[0];
    endsequence
    // Reset must reach every flop before the clocks stop
    sequence rst_lead;
        o_block_clk_en[0] [*4] ##[1:4] !o_block_clk_en[0];
    endsequence

    reset_fanout_a:
        assert property ((&o_block_reset) || (o_block_reset == '0))
        else $error("Block resets disagree");
    clock_fanout_a:
        assert property ((&o_block_clk_en) || (o_block_clk_en == '0))
        else $error("Block clock enables disagree");
    stopped_in_reset_a:
        assert property (!o_block_clk_en[0] |-> o_block_reset[0])
        else $error("Clock stopped while reset released");
    release_order_a:
        assert property ($rose(o_block_clk_en[0]) |-> clk_lead)
        else $error("Reset release not after clock settle");
    shutdown_order_a:
        assert property ($rose(o_block_reset[0]) |-> rst_lead)
        else $error("Clock stop not after reset hold");
    write_answer_a:
        assert property (i_awvalid && o_awready && i_wvalid && o_wready
            |=> !o_awready ##1 o_bvalid)
        else $error("Write response late");
    read_answer_a:
        assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
        else $error("Read response late");
    bresp_hold_a:
        assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("Write response dropped early");
    rdata_hold_a:
        assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("Read data dropped early");
endmodule : peripheral_block_enable_control_chk

bind peripheral_block_enable_control peripheral_block_enable_control_chk #(
    .NUM_BLOCKS(NUM_BLOCKS), .ADDR_W(ADDR_W)
) u_chk (
    .i_clock(i_clock), .i_rst(i_rst), .i_awvalid(i_awvalid),
    .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .i_rready(i_rready),
    .o_block_reset(o_block_reset), .o_block_clk_en(o_block_clk_en)
);

// >>> tb_top.sv
// Self-checking bench for the peripheral block enable control
`timescale 1ns/1ps
module tb_top;
    // Bus drive, initialised at time zero
    logic        i_clock = 1'b0;
    logic        i_rst = 1'b1;
    logic [7:0]  i_awaddr = 8'h00, i_araddr = 8'h00;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic [3:0]  i_wstrb = 4'h0;
    logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic        i_arvalid = 1'b0, i_rready = 1'b0;
    // Design outputs
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [1:0]  o_bresp, o_rresp;
    logic [31:0] o_rdata, o_periph_settings;
    logic [8:0]  o_block_reset, o_block_clk_en;
    // Bookkeeping
    int          num_errors = 0, checks = 0, cycles = 0;
    int          ready_lag = 0;  // Cycles bready and rready hang back
    logic [31:0] rd;
    logic [1:0]  rsp;
    localparam logic [7:0] ge_addr = block_enable_pkg::GLOBAL_ENABLE_OFFSET;
    localparam logic [7:0] es_addr = block_enable_pkg::ENABLE_STATUS_OFFSET;
    localparam logic [7:0] ps_addr = block_enable_pkg::PERIPH_SETTINGS_OFFSET;
    localparam logic [1:0] okay = block_enable_pkg::RESP_OKAY;
    localparam logic [1:0] slverr = block_enable_pkg::RESP_SLVERR;

    // 40 MHz clock
    always #12.5 i_clock = ~i_clock;

    peripheral_block_enable_control dut (
        .i_clock(i_clock), .i_rst(i_rst), .i_awaddr(i_awaddr),
        .i_awprot(3'h0), .i_awvalid(i_awvalid), .o_awready(o_awready),
        .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
        .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
        .i_bready(i_bready), .i_araddr(i_araddr), .i_arprot(3'h0),
        .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata),
        .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
        .o_block_reset(o_block_reset), .o_block_clk_en(o_block_clk_en),
        .o_periph_settings(o_periph_settings)
    );

    // Verdict and end of run
    task automatic finish_test;
        $display("Comparisons %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test

    // Hang guard, far above the hundred or so cycles the tests need
    always @(posedge i_clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            num_errors++;
            finish_test();
        end
    end

    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        checks++;
        if (exp !== got)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // Write: address and data offered together, each released when taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             input logic [3:0] s);
        logic aw_open;
        logic w_open;
        @(posedge i_clock);
        i_awaddr <= a;
        i_wdata <= d;
        i_wstrb <= s;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= (ready_lag == 0);
        aw_open = 1'b1;
        w_open = 1'b1;
        while (aw_open || w_open)
        begin
            @(posedge i_clock);
            if (aw_open && o_awready === 1'b1)
            begin
                aw_open = 1'b0;
                i_awvalid <= 1'b0;
            end
            if (w_open && o_wready === 1'b1)
            begin
                w_open = 1'b0;
                i_wvalid <= 1'b0;
            end
        end
        // A late bready lets the response stand for a few cycles
        if (ready_lag > 0)
        begin
            repeat (ready_lag) @(posedge i_clock);
            i_bready <= 1'b1;
            @(posedge i_clock);
        end
        while (o_bvalid !== 1'b1)
            @(posedge i_clock);
        rsp = o_bresp;
        i_bready <= 1'b0;
    endtask : axi_write

    // Read: address held until taken, rready held until data comes when ready_lag is 0
    task automatic axi_read(input logic [7:0] a);
        @(posedge i_clock);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= (ready_lag == 0);
        do @(posedge i_clock); while (o_arready !== 1'b1);
        i_arvalid <= 1'b0;
        // A late rready lets the read data stand for a few cycles
        if (ready_lag > 0)
        begin
            repeat (ready_lag) @(posedge i_clock);
            i_rready <= 1'b1;
            @(posedge i_clock);
        end
        while (o_rvalid !== 1'b1)
            @(posedge i_clock);
        rd = o_rdata;
        rsp = o_rresp;
        i_rready <= 1'b0;
    endtask : axi_read

    task automatic wr_chk(input string name, input logic [7:0] a,
                          input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] exp_rsp);
        axi_write(a, d, s);
        check({name, " resp"}, {30'h0, exp_rsp}, {30'h0, rsp});
    endtask : wr_chk

    task automatic rd_chk(input string name, input logic [7:0] a,
                          input logic [31:0] exp, input logic [1:0] exp_rsp);
        axi_read(a);
        check(name, exp, rd);
        check({name, " resp"}, {30'h0, exp_rsp}, {30'h0, rsp});
    endtask : rd_chk

    // Software polls status until the sequence reports done
    task automatic poll_status(input logic [31:0] exp);
        for (int n = 0; n < 16; n++)
        begin
            axi_read(es_addr);
            if (rd === exp)
                break;
        end
        check("enable_status poll", exp, rd);
    endtask : poll_status

    // Main sequence
    initial
    begin
        repeat (10) @(posedge i_clock);
        i_rst <= 1'b0;
        rd_chk("global_enable", ge_addr, 32'h0, okay);
        rd_chk("enable_status", es_addr, 32'h0, okay);
        check("block_reset", 32'h1FF, {23'h0, o_block_reset});
        check("block_clk_en", 32'h0, {23'h0, o_block_clk_en});
        // Only bit 0 of the enable is stored
        wr_chk("enable write", ge_addr, 32'hFFFF_FFFF, 4'hF, okay);
        rd_chk("global_enable", ge_addr, 32'h1, okay);
        poll_status(32'h3FF);
        check("block_reset", 32'h0, {23'h0, o_block_reset});
        check("block_clk_en", 32'h1FF, {23'h0, o_block_clk_en});
        // Status ignores writes; unmapped places refuse
        wr_chk("status write", es_addr, 32'h0, 4'hF, slverr);
        rd_chk("enable_status", es_addr, 32'h3FF, okay);
        wr_chk("unmapped write", 8'h3C, 32'hA5A5_A5A5, 4'hF, slverr);
        rd_chk("unmapped read", 8'h3C, 32'h0, slverr);
        // Settings on two lanes, unused PLL bits written as zero
        wr_chk("settings write", ps_addr, 32'h1234_56F0, 4'h3, okay);
        rd_chk("settings", ps_addr, 32'h0000_56F0, okay);
        check("settings port", 32'h0000_56F0, o_periph_settings);
        // Slow acceptance: responses must stand until taken
        ready_lag = 3;
        wr_chk("slow write", ps_addr, 32'h0000_0A50, 4'hF, okay);
        rd_chk("slow read", ps_addr, 32'h0000_0A50, okay);
        ready_lag = 0;
        // Shutdown back to all off
        wr_chk("disable write", ge_addr, 32'h0, 4'hF, okay);
        poll_status(32'h0);
        check("block_reset", 32'h1FF, {23'h0, o_block_reset});
        check("block_clk_en", 32'h0, {23'h0, o_block_clk_en});
        // Enable by lane 0 only, then reset in mid-run
        wr_chk("enable lane0", ge_addr, 32'h1, 4'h1, okay);
        poll_status(32'h3FF);
        @(posedge i_clock);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clock);
        i_rst <= 1'b0;
        rd_chk("global_enable", ge_addr, 32'h0, okay);
        rd_chk("enable_status", es_addr, 32'h0, okay);
        check("block_reset", 32'h1FF, {23'h0, o_block_reset});
        check("block_clk_en", 32'h0, {23'h0, o_block_clk_en});
        finish_test();
    end
endmodule : tb_top
